/* fsc_coder.sv */
// fsc_coder.sv: 100 Mb/s symbol coder: 4B/5B encode, scramble, serialise, NRZI and MLT-3 out;
// delimiter and code checking with 5B/4B decode on receive.
// Assumes: aligned, descrambled receive code-groups arrive at most one per two clocks.
// Function
// - each nibble maps to its fixed 5-bit code-group; decoder applies the inverse.
// - first end symbol drops carrier only if second end symbol follows, else error.
// - second end symbol ends carrier only right after the first; elsewhere under carrier, error; ignored in idle.
// - invalid code-groups during data valid raise receive error; transmitter never sends them.
// - start pair raises data valid and yields two nibbles 0101.
// - bad start pair raises error with nibble 1110, data valid stays low.
// - end pair or two idles drop carrier and data valid, not translated.
// - scrambler seed comes from the PHY address.
// - scrambler stage also serialises each code-group.
// - NRZI converter takes the scrambled serial bits, emits a serial stream at 125 MHz.
// - MLT-3 steps level on each one bit, holds on each zero bit.
// - all coding logic runs on the 125 MHz PLL clock.
`timescale 1ns/1ps
`include "fsc_defines.svh"
module fsc_coder import fsc_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [4:0] phy_addr,
    input wire logic tx_valid,
    input wire logic tx_en,
    input wire logic tx_er,
    input wire logic [3:0] txd,
    output logic tx_ready,
    output logic nrzi_out,
    output logic mlt3_pos,
    output logic mlt3_neg,
    input wire logic rx_code_valid,
    input wire logic [4:0] rx_code,
    output logic rx_strobe,
    output logic rx_dv,
    output logic rx_er,
    output logic [3:0] rxd,
    output logic crs
);
    localparam logic [4:0] ENC_TBL [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    fsc_stream_if #(.WIDTH(`FSC_SYM_BITS)) enc_if ();
    fsc_stream_if #(.WIDTH(`FSC_SYM_BITS)) ser_if ();

    fsc_fifo #(.WIDTH(`FSC_SYM_BITS), .DEPTH(`FSC_FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .wr(enc_if.snk),
        .rd(ser_if.src)
    );

    // transmit encoder
    fsc_tx_state_type tx_st_q, tx_st_d;
    logic [4:0] data_code;
    logic [4:0] last_code_q;

    assign data_code = tx_er ? `FSC_CG_TXERR : ENC_TBL[txd];
    assign enc_if.valid = (tx_st_q == TX_ESD2) || (tx_valid && (tx_st_q != TX_IDLE || tx_en));
    assign tx_ready = enc_if.ready && (tx_st_q != TX_ESD2);
    wire enc_fire = enc_if.valid && enc_if.ready;

    always_comb begin
        tx_st_d = tx_st_q;
        enc_if.data = `FSC_CG_IDLE;
        unique case (tx_st_q)
            TX_IDLE: begin
                enc_if.data = `FSC_CG_SSD1;
                if (enc_fire) tx_st_d = TX_SSD2;
            end
            TX_SSD2: begin
                enc_if.data = `FSC_CG_SSD2;
                if (enc_fire) tx_st_d = TX_DATA;
            end
            TX_DATA: begin
                enc_if.data = tx_en ? data_code : `FSC_CG_ESD1;
                if (enc_fire && !tx_en) tx_st_d = TX_ESD2;
            end
            TX_ESD2: begin
                enc_if.data = `FSC_CG_ESD2;
                if (enc_fire) tx_st_d = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tx_st_q <= TX_IDLE;
            last_code_q <= `FSC_CG_IDLE;
        end else begin
            tx_st_q <= tx_st_d;
            if (enc_fire) last_code_q <= enc_if.data;
        end
    end

    a_tx_never_invalid: assert property (enc_if.valid |-> !(enc_if.data inside {`FSC_CG_BAD0, `FSC_CG_BAD1,
        `FSC_CG_BAD2, `FSC_CG_BAD3, `FSC_CG_BAD5, `FSC_CG_BAD6, `FSC_CG_BAD8, `FSC_CG_BADC, `FSC_CG_BAD10,
        `FSC_CG_BAD19})) else $error("transmitter queued an invalid code-group");
    a_tx_start_pair: assert property (enc_fire && last_code_q == `FSC_CG_SSD1 |-> enc_if.data == `FSC_CG_SSD2)
        else $error("start pair not sent in order");
    a_tx_end_pair: assert property (enc_fire && last_code_q == `FSC_CG_ESD1 |-> enc_if.data == `FSC_CG_ESD2)
        else $error("end pair not sent in order");

    // scrambler, serialiser, NRZI and MLT-3 line coding
    logic [2:0] bit_cnt_q;
    logic [4:0] shift_q;
    logic [`FSC_LFSR_BITS-1:0] lfsr_q;
    logic nrzi_q;
    fsc_mlt3_type lvl_q, lvl_d;

    wire load = (bit_cnt_q == `FSC_BIT_LAST);
    assign ser_if.ready = load;
    // an empty fifo means no frame data waiting, so idle fills the line
    wire [4:0] next_sym = ser_if.valid ? ser_if.data : `FSC_CG_IDLE;
    wire [`FSC_LFSR_BITS-1:0] seed = {1'b1, phy_addr, phy_addr ^ `FSC_SEED_MIX};
    wire scr_bit = shift_q[4] ^ lfsr_q[`FSC_LFSR_BITS-1];
    wire lfsr_fb = lfsr_q[10] ^ lfsr_q[8];

    always_comb begin
        lvl_d = lvl_q;
        if (scr_bit) begin
            unique case (lvl_q)
                LVL_ZERO_UP: lvl_d = LVL_POS;
                LVL_POS: lvl_d = LVL_ZERO_DN;
                LVL_ZERO_DN: lvl_d = LVL_NEG;
                LVL_NEG: lvl_d = LVL_ZERO_UP;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bit_cnt_q <= 3'h0;
            shift_q <= `FSC_CG_IDLE;
            lfsr_q <= seed;
            nrzi_q <= 1'b0;
            lvl_q <= LVL_ZERO_UP;
        end else begin
            bit_cnt_q <= load ? 3'h0 : bit_cnt_q + 3'h1;
            shift_q <= load ? next_sym : {shift_q[3:0], 1'b0};
            lfsr_q <= {lfsr_q[9:0], lfsr_fb};
            nrzi_q <= nrzi_q ^ scr_bit;
            lvl_q <= lvl_d;
        end
    end

    assign nrzi_out = nrzi_q;
    assign mlt3_pos = (lvl_q == LVL_POS);
    assign mlt3_neg = (lvl_q == LVL_NEG);

    a_ser_symbol_rate: assert property (load |=> !load [*4] ##1 load)
        else $error("serialiser not taking one code-group per five bits");
    a_nrzi_toggle: assert property (scr_bit |=> nrzi_out != $past(nrzi_out))
        else $error("NRZI did not toggle on a one");
    a_mlt3_levels: assert property (!scr_bit |=> $stable(lvl_q) and $stable(mlt3_pos))
        else $error("MLT-3 level moved on a zero");
    a_mlt3_step: assert property (scr_bit |=> lvl_q != $past(lvl_q))
        else $error("MLT-3 level held on a one");
    a_seed_nonzero: assert property (lfsr_q != '0)
        else $error("scrambler locked at zero");

    // receive decoder
    logic [15:0] hit;
    logic [3:0] rx_nib;
    for (genvar i = 0; i < 16; i++) begin : g_dec
        assign hit[i] = (rx_code == ENC_TBL[i]);
    end
    always_comb begin
        rx_nib = 4'h0;
        for (int j = 0; j < 16; j++) begin
            if (hit[j]) rx_nib = 4'(j);
        end
    end
    wire is_data = |hit;
    wire is_idle = (rx_code == `FSC_CG_IDLE);

    fsc_rx_state_type rx_st_q, rx_st_d;
    logic strobe_d, dv_d, er_d, crs_d, ssd2_q, ssd2_d;
    logic [3:0] rxd_d;

    always_comb begin
        rx_st_d = rx_st_q;
        strobe_d = ssd2_q;
        er_d = 1'b0;
        dv_d = rx_dv;
        crs_d = crs;
        rxd_d = ssd2_q ? `FSC_NIB_SSD : rxd;
        ssd2_d = 1'b0;
        if (rx_code_valid) begin
            unique case (rx_st_q)
                RX_IDLE: begin
                    if (rx_code == `FSC_CG_SSD1) begin
                        crs_d = 1'b1;
                        rx_st_d = RX_SSD1;
                    end
                end
                RX_SSD1: begin
                    if (rx_code == `FSC_CG_SSD2) begin
                        dv_d = 1'b1;
                        strobe_d = 1'b1;
                        rxd_d = `FSC_NIB_SSD;
                        ssd2_d = 1'b1;
                        rx_st_d = RX_DATA;
                    end else begin
                        er_d = 1'b1;
                        strobe_d = 1'b1;
                        rxd_d = `FSC_NIB_BAD_SSD;
                        dv_d = 1'b0;
                        crs_d = 1'b0;
                        rx_st_d = RX_IDLE;
                    end
                end
                RX_DATA: begin
                    strobe_d = 1'b1;
                    if (is_data) begin
                        rxd_d = rx_nib;
                    end else if (rx_code == `FSC_CG_ESD1) begin
                        strobe_d = 1'b0;
                        rx_st_d = RX_ESD1;
                    end else if (is_idle) begin
                        strobe_d = 1'b0;
                        rx_st_d = RX_IDL1;
                    end else begin
                        er_d = 1'b1;
                    end
                end
                RX_ESD1, RX_IDL1: begin
                    if ((rx_st_q == RX_ESD1 && rx_code == `FSC_CG_ESD2) ||
                        (rx_st_q == RX_IDL1 && is_idle)) begin
                        dv_d = 1'b0;
                        crs_d = 1'b0;
                        rx_st_d = RX_IDLE;
                    end else begin
                        er_d = 1'b1;
                        strobe_d = 1'b1;
                        rx_st_d = RX_DATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rx_st_q <= RX_IDLE;
            ssd2_q <= 1'b0;
            rx_strobe <= 1'b0;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rxd <= 4'h0;
            crs <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            ssd2_q <= ssd2_d;
            rx_strobe <= strobe_d;
            rx_dv <= dv_d;
            rx_er <= er_d;
            rxd <= rxd_d;
            crs <= crs_d;
        end
    end

    sequence s_ssd_seen;
        rx_code_valid && rx_st_q == RX_SSD1 && rx_code == `FSC_CG_SSD2;
    endsequence
    sequence s_two_preamble;
        (rx_strobe && rx_dv && rxd == `FSC_NIB_SSD) [*2];
    endsequence
    a_rx_ssd_pair: assert property (s_ssd_seen |=> s_two_preamble)
        else $error("start pair not presented as two 0101 nibbles");
    a_rx_bad_ssd: assert property (rx_code_valid && rx_st_q == RX_SSD1 && rx_code != `FSC_CG_SSD2
        |=> rx_er && !rx_dv && rxd == `FSC_NIB_BAD_SSD) else $error("bad start pair not flagged");
    a_rx_esd_end: assert property (rx_code_valid && rx_st_q == RX_ESD1 && rx_code == `FSC_CG_ESD2
        |=> !crs && !rx_dv && !rx_strobe) else $error("end pair did not drop carrier");
    a_rx_lone_esd2: assert property (rx_code_valid && rx_st_q == RX_DATA && rx_code == `FSC_CG_ESD2
        |=> rx_er && crs) else $error("misplaced second end symbol not flagged");
    a_rx_invalid_err: assert property (rx_code_valid && rx_dv && rx_st_q == RX_DATA
        && rx_code inside {`FSC_CG_BAD0, `FSC_CG_BAD6, `FSC_CG_BAD19} |=> rx_er) else $error("invalid code not flagged");
    a_rx_two_idles: assert property (rx_code_valid && rx_st_q == RX_IDL1 && is_idle
        |=> !rx_dv && !crs && !rx_strobe) else $error("two idles did not end the frame");
    a_rx_decode: assert property (rx_code_valid && rx_st_q == RX_DATA && is_data
        |=> rx_strobe && rxd == $past(rx_nib)) else $error("data code-group decoded wrongly");

endmodule : fsc_coder

/* fsc_coder_test.sv */
// fsc_coder_test.sv: self-checking bench for the symbol coder.
// Assumes: fsc_mac_model stands on the mac side; the line is descrambled here from idle.
`timescale 1ns/1ps
`include "fsc_defines.svh"
module fsc_coder_test;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] phy_addr = 5'h03;
    logic tx_valid, tx_en, tx_er, tx_ready, nrzi_out, mlt3_pos, mlt3_neg;
    logic [3:0] txd, rxd;
    logic rx_code_valid = 1'b0;
    logic [4:0] rx_code = 5'h1F;
    logic rx_strobe, rx_dv, rx_er, crs;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int bit_n, miss_a, miss_b, nrzi_tog, mlt_chg;
    logic nrzi_p;
    logic [10:0] key_h = 11'h000;
    logic [1:0] mlt_p, lvl_last;
    bit plain_q[$];
    localparam logic [4:0] CG_TAB [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    localparam logic [4:0] BAD_TAB [10] = '{5'h00, 5'h06, 5'h19, 5'h01, 5'h02, 5'h03, 5'h05, 5'h08,
        5'h0C, 5'h10};

    fsc_coder u_fsc_coder (.mclk(mclk), .nrst(nrst), .phy_addr(phy_addr), .tx_valid(tx_valid),
        .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .tx_ready(tx_ready), .nrzi_out(nrzi_out),
        .mlt3_pos(mlt3_pos), .mlt3_neg(mlt3_neg), .rx_code_valid(rx_code_valid), .rx_code(rx_code),
        .rx_strobe(rx_strobe), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .crs(crs));
    fsc_mac_model u_fsc_mac_model (.mclk(mclk), .nrst(nrst), .tx_valid(tx_valid), .tx_en(tx_en),
        .tx_er(tx_er), .txd(txd), .tx_ready(tx_ready), .rx_strobe(rx_strobe), .rx_dv(rx_dv),
        .rx_er(rx_er), .rxd(rxd));

    always #(`FSC_CLK_PERIOD_NS / 2) mclk = ~mclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // keystream learnt from idle (all-ones code bits), then predicted by the lfsr recurrence
    always @(posedge mclk) begin : line_watch
        logic s, k, ka, kb;
        logic [1:0] lv;
        if (!nrst) begin
            {bit_n, miss_a, miss_b, nrzi_tog, mlt_chg} = '0;
            nrzi_p = 1'b0;
            mlt_p = 2'b00;
            lvl_last = 2'b01;
            plain_q.delete();
        end else begin
            s = nrzi_out ^ nrzi_p;
            ka = key_h[8] ^ key_h[10];
            kb = key_h[1] ^ key_h[10];
            k = (miss_a <= miss_b) ? ka : kb;
            if (bit_n < 100) begin
                k = ~s;
                miss_a += (bit_n > 40 && ka != k) ? 1 : 0;
                miss_b += (bit_n > 40 && kb != k) ? 1 : 0;
            end else begin
                plain_q.push_back(s ^ k);
            end
            key_h = {key_h[9:0], k};
            lv = {mlt3_pos, mlt3_neg};
            if (lv != mlt_p) begin
                mlt_chg++;
                if (lv != 2'b00) begin
                    check(lv != 2'b11 && lv != lvl_last && mlt_p == 2'b00, 1);
                    lvl_last = lv;
                end
            end
            nrzi_tog += s ? 1 : 0;
            nrzi_p = nrzi_out;
            mlt_p = lv;
            bit_n++;
        end
    end

    task automatic send_code(input logic [4:0] c);
        rx_code <= c;
        rx_code_valid <= 1'b1;
        @(posedge mclk);
        rx_code_valid <= 1'b0;
        rx_code <= ~c;
        repeat (3) @(posedge mclk);
    endtask : send_code

    task automatic expect_rx(input logic [5:0] e, input logic [5:0] m);
        logic [5:0] got;
        got = (u_fsc_mac_model.rx_q.size() > 0) ? u_fsc_mac_model.rx_q.pop_front() : 6'h3F;
        check(got & m, e & m);
    endtask : expect_rx

    task automatic test_rx_frame();
        send_code(`FSC_CG_SSD1);
        check(crs, 1'b1);
        send_code(`FSC_CG_SSD2);
        for (int i = 0; i < 16; i++) begin
            send_code(CG_TAB[i]);
        end
        send_code(`FSC_CG_ESD1);
        check({crs, rx_dv}, 2'b11);
        send_code(`FSC_CG_ESD2);
        check({crs, rx_dv}, 2'b00);
        expect_rx({2'b01, `FSC_NIB_SSD}, 6'h3F);
        expect_rx({2'b01, `FSC_NIB_SSD}, 6'h3F);
        for (int i = 0; i < 16; i++) begin
            expect_rx({2'b01, 4'(i)}, 6'h3F);
        end
        check(u_fsc_mac_model.rx_q.size(), 0);
        $display("test_rx_frame done");
    endtask : test_rx_frame

    task automatic test_bad_ssd();
        send_code(`FSC_CG_SSD1);
        send_code(CG_TAB[0]);
        expect_rx({2'b10, `FSC_NIB_BAD_SSD}, 6'h3F);
        check({crs, rx_dv}, 2'b00);
        $display("test_bad_ssd done");
    endtask : test_bad_ssd

    task automatic test_rx_errors();
        send_code(`FSC_CG_SSD1);
        send_code(`FSC_CG_SSD2);
        u_fsc_mac_model.rx_q.delete();
        for (int i = 0; i < 10; i++) begin
            send_code(BAD_TAB[i]);
            expect_rx(6'h30, 6'h30);
        end
        send_code(`FSC_CG_ESD2);
        expect_rx(6'h30, 6'h30);
        send_code(`FSC_CG_ESD1);
        send_code(CG_TAB[1]);
        expect_rx(6'h30, 6'h30);
        check(crs, 1'b1);
        send_code(`FSC_CG_IDLE);
        send_code(CG_TAB[2]);
        expect_rx(6'h30, 6'h30);
        check(crs, 1'b1);
        u_fsc_mac_model.rx_q.delete();
        send_code(`FSC_CG_IDLE);
        send_code(`FSC_CG_IDLE);
        check({crs, rx_dv, u_fsc_mac_model.rx_q.size() > 0}, 3'b000);
        $display("test_rx_errors done");
    endtask : test_rx_errors

    task automatic test_tx_frame();
        logic [4:0] exp_q[$];
        logic [4:0] g;
        int p, d;
        for (int i = 0; i < 200 && bit_n < 100; i++) @(posedge mclk);
        check(miss_a == 0 || miss_b == 0, 1);
        exp_q = {`FSC_CG_SSD1, `FSC_CG_SSD2};
        u_fsc_mac_model.push_slot(6'h25);
        u_fsc_mac_model.push_slot(6'h25);
        for (int i = 0; i < 16; i++) begin
            u_fsc_mac_model.push_slot({2'b10, 4'(i)});
            exp_q.push_back(CG_TAB[i]);
        end
        u_fsc_mac_model.push_slot(6'h30);
        u_fsc_mac_model.push_slot(6'h00);
        exp_q = {exp_q, `FSC_CG_TXERR, `FSC_CG_ESD1, `FSC_CG_ESD2, `FSC_CG_IDLE, `FSC_CG_IDLE};
        for (int i = 0; i < 400 && (tx_valid || u_fsc_mac_model.slot_q.size() > 0); i++) @(posedge mclk);
        repeat (60) @(posedge mclk);
        g = 5'h1F;
        for (p = 0; p < plain_q.size() && g != `FSC_CG_SSD1; p++) g = {g[3:0], plain_q[p]};
        p = p - 5;
        foreach (exp_q[i]) begin
            for (int j = 0; j < 5; j++) g = {g[3:0], plain_q[p + 5 * i + j]};
            check(g, exp_q[i]);
        end
        d = nrzi_tog - mlt_chg;
        check(d >= -2 && d <= 2, 1);
        $display("test_tx_frame done");
    endtask : test_tx_frame

    task automatic test_seed();
        logic [63:0] seq [3];
        logic [4:0] addr [3];
        addr = '{5'h03, 5'h0C, 5'h03};
        for (int k = 0; k < 3; k++) begin
            nrst <= 1'b0;
            phy_addr <= addr[k];
            repeat (20) @(posedge mclk);
            check({tx_ready, nrzi_out, mlt3_pos, mlt3_neg, rx_strobe, rx_dv, rx_er, crs, rxd}, 12'h800);
            nrst <= 1'b1;
            repeat (20) @(posedge mclk);
            for (int j = 0; j < 64; j++) begin
                seq[k][j] = nrzi_out;
                @(posedge mclk);
            end
        end
        check(seq[0] != seq[1], 1);
        check(seq[0][31:0], seq[2][31:0]);
        check(seq[0][63:32], seq[2][63:32]);
        $display("test_seed done");
    endtask : test_seed

    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        test_rx_frame();
        test_bad_ssd();
        test_rx_errors();
        test_tx_frame();
        test_seed();
        stop_test();
    end
endmodule : fsc_coder_test

/* fsc_defines.svh */
// fsc_defines.svh: code-group values, nibble values, timing counts and fifo depth for the symbol coder.
// Assumes: included by bare name; definitions only.
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH

// control code-groups
`define FSC_CG_IDLE 5'h1F
`define FSC_CG_SSD1 5'h18
`define FSC_CG_SSD2 5'h11
`define FSC_CG_ESD1 5'h0D
`define FSC_CG_ESD2 5'h07
`define FSC_CG_TXERR 5'h04
// invalid code-groups
`define FSC_CG_BAD0 5'h00
`define FSC_CG_BAD1 5'h01
`define FSC_CG_BAD2 5'h02
`define FSC_CG_BAD3 5'h03
`define FSC_CG_BAD5 5'h05
`define FSC_CG_BAD6 5'h06
`define FSC_CG_BAD8 5'h08
`define FSC_CG_BADC 5'h0C
`define FSC_CG_BAD10 5'h10
`define FSC_CG_BAD19 5'h19

// nibbles on the receive side
`define FSC_NIB_SSD 4'h5
`define FSC_NIB_BAD_SSD 4'hE

// serialiser: code-group width and index of its last bit
`define FSC_SYM_BITS 5
`define FSC_BIT_LAST 3'h4
// link clock period in ns (125 MHz)
`define FSC_CLK_PERIOD_NS 8

// fifo between encoder and serialiser
`define FSC_FIFO_DEPTH 4

// scrambler: width and mask xored into the second copy of the address bits
`define FSC_LFSR_BITS 11
`define FSC_SEED_MIX 5'h15

`endif

/* fsc_fifo.sv */
// fsc_fifo.sv: small synchronous fifo with valid/ready on both sides.
// Assumes: DEPTH is a power of two; single clock, synchronous active-low reset.
`timescale 1ns/1ps
module fsc_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic nrst,
    fsc_stream_if.snk wr,
    fsc_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] cnt_q;

    wire full = (cnt_q == (AW+1)'(DEPTH));
    wire empty = (cnt_q == '0);
    wire push = wr.valid && !full;
    wire pop = rd.ready && !empty;

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rptr_q];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wptr_q] <= wr.data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
        end else begin
            wptr_q <= wptr_q + AW'(push);
            rptr_q <= rptr_q + AW'(pop);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : fsc_fifo

/* fsc_mac_model.sv */
// fsc_mac_model.sv: switch-side mac model that feeds transmit slots and logs receive nibbles.
// Assumes: the bench queues slots with push_slot; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module fsc_mac_model (
    input wire logic mclk,
    input wire logic nrst,
    output logic tx_valid,
    output logic tx_en,
    output logic tx_er,
    output logic [3:0] txd,
    input wire logic tx_ready,
    input wire logic rx_strobe,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic [3:0] rxd
);
    logic [5:0] slot_q[$];
    logic [5:0] rx_q[$];

    // slot layout {en, er, nibble}
    task automatic push_slot(input logic [5:0] s);
        slot_q.push_back(s);
    endtask : push_slot

    initial begin
        tx_valid = 1'b0;
        {tx_en, tx_er, txd} = 6'h00;
    end

    // an offered slot stays put until the edge that takes it
    always @(posedge mclk) begin
        if (!nrst) begin
            tx_valid <= 1'b0;
        end else if (!tx_valid || tx_ready) begin
            if (slot_q.size() > 0) begin
                tx_valid <= 1'b1;
                {tx_en, tx_er, txd} <= slot_q.pop_front();
            end else begin
                tx_valid <= 1'b0;
                txd <= ~txd;
            end
        end
        if (nrst && rx_strobe) begin
            rx_q.push_back({rx_er, rx_dv, rxd});
        end
    end
endmodule : fsc_mac_model

/* fsc_pkg.sv */
// fsc_pkg.sv: state types for the symbol coder.
// Assumes: fsc_defines.svh holds the numeric constants.
package fsc_pkg;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_SSD2 = 4'b0010,
        TX_DATA = 4'b0100,
        TX_ESD2 = 4'b1000
    } fsc_tx_state_type;

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_SSD1 = 5'b00010,
        RX_DATA = 5'b00100,
        RX_ESD1 = 5'b01000,
        RX_IDL1 = 5'b10000
    } fsc_rx_state_type;

    typedef enum logic [3:0] {
        LVL_ZERO_UP = 4'b0001,
        LVL_POS = 4'b0010,
        LVL_ZERO_DN = 4'b0100,
        LVL_NEG = 4'b1000
    } fsc_mlt3_type;

endpackage : fsc_pkg

/* fsc_stream_if.sv */
// fsc_stream_if.sv: valid/ready word stream between the coder's own modules.
// Assumes: one clock shared by both ends.
`timescale 1ns/1ps
interface fsc_stream_if #(parameter int WIDTH = 5);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : fsc_stream_if
